// file: rtl/car_arch_regs.sv
// Architectural registers of the core: general registers, program counter, status.
// Assumes one processor clock; the core sequences moves and hardware events.
//
// What this block does
// - Register zero reads zero, writes dropped.
// - Thirty-two general registers, 32 or 64 bits.
// - General registers zero after configuration load.
// - External and debug resets leave general registers alone.
// - Interrupt return address goes to register fourteen.
// - Break return address goes to register sixteen.
// - Exception return to seventeen, delay slot elsewhere.
// - Bit zero is the most significant bit.
// - Program counter readable, move-to-special ignored.
// - Selector zero picks the program counter.
// - Program counter width follows configuration.
// - Reading counter returns the reading instruction address.
// - Status read shows carry in copy bit.
// - Bit ops: carry now, others next cycle.
// - Status move: all bits next cycle.
// - Writes to the carry copy bit ignored.
// - Selector one picks the machine status.
// - At most sixteen special registers implemented.
// - Copy bit at 0 or 32, equals carry.
`timescale 1ns/1ps
module car_arch_regs #(
  parameter int DATA_W = car_pkg::DATA_W_DEF,
  parameter int ADDR_W = car_pkg::ADDR_W_DEF,
  parameter bit EXC_SUPPORT = 1'b1,
  parameter int NUM_SPECIAL = car_pkg::NUM_SPECIAL_DEF,
  parameter logic [63:0] VECTOR_BASE_PARAM = car_pkg::VECTOR_BASE_DEF,
  localparam int PC_W = (DATA_W == 64) ? ADDR_W : 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [car_pkg::GPR_IDX_W-1:0] rd_a_addr,
  input wire logic [car_pkg::GPR_IDX_W-1:0] rd_b_addr,
  output logic [DATA_W-1:0] rd_a_data,
  output logic [DATA_W-1:0] rd_b_data,
  input wire logic wb_en,
  input wire logic [car_pkg::GPR_IDX_W-1:0] wb_addr,
  input wire logic [DATA_W-1:0] wb_data,
  input wire logic irq_take,
  input wire logic brk_take,
  input wire logic exc_take,
  input wire logic exc_in_delay,
  input wire logic [PC_W-1:0] ret_addr,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_next,
  output logic [PC_W-1:0] program_counter,
  input wire logic mfs_en,
  input wire logic mts_en,
  input wire logic [car_pkg::SEL_W-1:0] special_selector,
  input wire logic [DATA_W-1:0] mts_data,
  output logic [DATA_W-1:0] mfs_data,
  input wire logic status_bit_set,
  input wire logic status_bit_clear,
  input wire logic [DATA_W-1:0] bitop_mask,
  input wire logic alu_carry_we,
  input wire logic alu_carry,
  output logic carry,
  output logic [DATA_W-1:0] machine_status,
  output logic [PC_W-1:0] branch_target_save
);
  import car_pkg::*;

  // Bit positions derived from big-endian numbering
  localparam int CC_IDX = car_msb_bit(DATA_W, (DATA_W == 64) ? CC_POS_64 : CC_POS_32);
  localparam int CARRY_IDX =
    car_msb_bit(DATA_W, (DATA_W == 64) ? CARRY_POS_64 : CARRY_POS_32);
  localparam logic [DATA_W-1:0] KEEP_MASK =
    ~((DATA_W'(1) << CARRY_IDX) | (DATA_W'(1) << CC_IDX));

  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] nxt_pc;
  logic [PC_W-1:0] btr_ff;
  logic [PC_W-1:0] nxt_btr;
  logic [DATA_W-1:0] mfs_ff;
  logic [DATA_W-1:0] nxt_mfs;
  logic [DATA_W-1:0] ret_ext;
  logic [DATA_W-1:0] pc_ext;
  logic [DATA_W-1:0] msr_view;
  logic exc_eff;
  logic exc_to_gpr;
  logic exc_to_btr;
  logic sel_pc;
  logic sel_msr;
  logic sel_known;
  logic mts_msr;
  logic carry_now;

  car_rf_if #(.W(DATA_W)) rf ();

  car_gpr_mem #(.W(DATA_W)) u_mem (
    .core_clk(core_clk),
    .rf(rf)
  );

  car_msr #(
    .W(DATA_W),
    .CARRY_IDX(CARRY_IDX),
    .CC_IDX(CC_IDX)
  ) u_msr (
    .core_clk(core_clk),
    .rst(rst),
    .mts_en(mts_msr),
    .mts_data(mts_data),
    .bitop_set(status_bit_set),
    .bitop_clr(status_bit_clear),
    .bitop_mask(bitop_mask),
    .alu_carry_we(alu_carry_we),
    .alu_carry(alu_carry),
    .carry_now(carry_now),
    .msr_read(msr_view)
  );

  // Special register selection; only two of the sixteen slots exist
  assign sel_pc = (special_selector == SEL_PC);
  assign sel_msr = (special_selector == SEL_MSR);
  assign sel_known = (NUM_SPECIAL <= MAX_SPECIAL) && (sel_pc || sel_msr);
  assign mts_msr = mts_en && sel_msr;

  // Hardware return addresses; exceptions exist only when configured
  assign exc_eff = EXC_SUPPORT && exc_take;
  assign exc_to_gpr = exc_eff && !exc_in_delay;
  assign exc_to_btr = exc_eff && exc_in_delay;
  assign ret_ext = DATA_W'(ret_addr);
  assign pc_ext = DATA_W'(pc_ff);

  // One write port: exception, then break, then interrupt, then pipeline
  assign rf.wen = exc_to_gpr || brk_take || irq_take || wb_en;
  assign rf.waddr = exc_to_gpr ? EXC_RET_IDX :
                    brk_take ? BRK_RET_IDX :
                    irq_take ? IRQ_RET_IDX : wb_addr;
  assign rf.wdata = (exc_to_gpr || brk_take || irq_take) ? ret_ext : wb_data;
  assign rf.ra_addr = rd_a_addr;
  assign rf.rb_addr = rd_b_addr;
  assign rd_a_data = rf.ra_data;
  assign rd_b_data = rf.rb_data;

  // Move-to-special never reaches the counter, only the pipeline load does
  assign nxt_pc = pc_load ? pc_next : pc_ff;
  assign nxt_btr = exc_to_btr ? ret_addr : btr_ff;
  // Counter always holds the executing instruction, so a read returns its own address
  assign nxt_mfs = !mfs_en ? mfs_ff :
                   (sel_pc && sel_known) ? pc_ext :
                   (sel_msr && sel_known) ? msr_view : '0;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_ff <= PC_W'(VECTOR_BASE_PARAM);
      btr_ff <= '0;
      mfs_ff <= '0;
    end else begin
      pc_ff <= nxt_pc;
      btr_ff <= nxt_btr;
      mfs_ff <= nxt_mfs;
    end
  end

  assign program_counter = pc_ff;
  assign branch_target_save = btr_ff;
  assign mfs_data = mfs_ff;
  assign carry = carry_now;
  assign machine_status = msr_view;

  a_zero_read: assert property (
    @(posedge core_clk) disable iff (rst)
    (rd_a_addr == ZERO_IDX) |=> (rd_a_data == '0)
  ) else $error("register zero read nonzero");

  a_irq_return: assert property (
    @(posedge core_clk) disable iff (rst)
    (irq_take && !brk_take && !exc_to_gpr) |->
      (rf.wen && rf.waddr == IRQ_RET_IDX && rf.wdata == ret_ext)
  ) else $error("interrupt return not written to fourteen");

  a_brk_return: assert property (
    @(posedge core_clk) disable iff (rst)
    (brk_take && !exc_to_gpr) ##1 (rd_a_addr == BRK_RET_IDX)
      |=> (rd_a_data == $past(ret_ext, 2))
  ) else $error("break return not readable from sixteen");

  a_exc_return: assert property (
    @(posedge core_clk) disable iff (rst)
    (exc_take && !exc_in_delay && EXC_SUPPORT) |->
      (rf.wen && rf.waddr == EXC_RET_IDX && rf.wdata == ret_ext)
  ) else $error("exception return not written to seventeen");

  a_exc_delay: assert property (
    @(posedge core_clk) disable iff (rst)
    (exc_take && exc_in_delay && EXC_SUPPORT) |->
      (rf.waddr != EXC_RET_IDX || !rf.wen || wb_en) ##1 (branch_target_save == $past(ret_addr))
  ) else $error("delay slot exception not saved in branch target");

  a_pc_no_mts: assert property (
    @(posedge core_clk) disable iff (rst)
    (mts_en && sel_pc && !pc_load) |=> $stable(program_counter)
  ) else $error("counter changed by move to special");

  a_pc_read: assert property (
    @(posedge core_clk) disable iff (rst)
    (mfs_en && special_selector == 16'h0000) |=> (mfs_data == DATA_W'($past(program_counter)))
  ) else $error("counter read returned wrong address");

  a_msr_read: assert property (
    @(posedge core_clk) disable iff (rst)
    (mfs_en && special_selector == 16'h0001) |=> (mfs_data == $past(machine_status))
  ) else $error("status read returned wrong value");

  a_unknown_sel: assert property (
    @(posedge core_clk) disable iff (rst)
    (mfs_en && special_selector > 16'h0001) |=> (mfs_data == '0)
  ) else $error("unimplemented special register read nonzero");

  a_carry_now: assert property (
    @(posedge core_clk) disable iff (rst)
    (status_bit_set && !mts_msr && bitop_mask[CARRY_IDX]) |-> carry
  ) else $error("carry set not immediate");

  a_bits_late: assert property (
    @(posedge core_clk) disable iff (rst)
    (status_bit_clear && !status_bit_set && !mts_msr) ##1 !(mts_msr || status_bit_set)
      |-> ((machine_status & $past(bitop_mask) & KEEP_MASK) == '0)
  ) else $error("status clear not applied next cycle");

  a_mts_late: assert property (
    @(posedge core_clk) disable iff (rst)
    mts_msr ##1 !(status_bit_set || status_bit_clear)
      |-> (carry == $past(mts_data[CARRY_IDX]) &&
           (machine_status & KEEP_MASK) == ($past(mts_data) & KEEP_MASK))
  ) else $error("status move not applied one cycle later");

  a_cc_copy: assert property (
    @(posedge core_clk) disable iff (rst)
    (machine_status[CC_IDX] == carry) && (machine_status[CARRY_IDX] == carry)
  ) else $error("carry copy differs from carry");

  a_cc_ignore: assert property (
    @(posedge core_clk) disable iff (rst)
    (mts_msr && mts_data[CC_IDX] != mts_data[CARRY_IDX]) ##1 !(status_bit_set || status_bit_clear)
      |-> (machine_status[CC_IDX] == $past(mts_data[CARRY_IDX]))
  ) else $error("written carry copy value was kept");

  a_zero_read_b: assert property (
    @(posedge core_clk) disable iff (rst)
    (rd_b_addr == ZERO_IDX) |=> (rd_b_data == '0)
  ) else $error("register zero read nonzero on port b");

  a_wb_readback: assert property (
    @(posedge core_clk) disable iff (rst)
    (wb_en && !irq_take && !brk_take && !exc_to_gpr && wb_addr != ZERO_IDX) ##1 !rf.wen
      ##1 (rd_a_addr == $past(wb_addr, 2)) |=> (rd_a_data == $past(wb_data, 3))
  ) else $error("pipeline write not read back");

  a_irq_readback: assert property (
    @(posedge core_clk) disable iff (rst)
    (irq_take && !brk_take && !exc_to_gpr) ##1 (rd_a_addr == IRQ_RET_IDX)
      |=> (rd_a_data == $past(ret_ext, 2))
  ) else $error("interrupt return not readable from fourteen");

  a_brk_write: assert property (
    @(posedge core_clk) disable iff (rst)
    (brk_take && !exc_to_gpr) |->
      (rf.wen && rf.waddr == BRK_RET_IDX && rf.wdata == ret_ext)
  ) else $error("break return not written to sixteen");

  a_exc_readback: assert property (
    @(posedge core_clk) disable iff (rst)
    exc_to_gpr ##1 (rd_a_addr == EXC_RET_IDX) |=> (rd_a_data == $past(ret_ext, 2))
  ) else $error("exception return not readable from seventeen");

  a_btr_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !exc_to_btr |=> $stable(branch_target_save)
  ) else $error("branch target save changed without delay slot exception");

  a_pc_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !pc_load |=> $stable(program_counter)
  ) else $error("counter changed without a load");

  a_pc_load: assert property (
    @(posedge core_clk) disable iff (rst)
    pc_load |=> (program_counter == $past(pc_next))
  ) else $error("counter load not taken");

  a_mfs_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !mfs_en |=> $stable(mfs_data)
  ) else $error("special read result changed without a read");

  a_cc_on_read: assert property (
    @(posedge core_clk) disable iff (rst)
    (mfs_en && special_selector == 16'h0001) |=> (mfs_data[CC_IDX] == $past(carry))
  ) else $error("status read lacks carry in copy bit");

  a_carry_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    (status_bit_clear && !status_bit_set && !mts_msr && bitop_mask[CARRY_IDX]) |-> !carry
  ) else $error("carry clear not immediate");

  a_msr_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !(mts_msr || status_bit_set || status_bit_clear)
      |=> ((machine_status & KEEP_MASK) == ($past(machine_status) & KEEP_MASK))
  ) else $error("status bits changed without a write");
endmodule : car_arch_regs

// file: rtl/car_pkg.sv
// Constants shared by the architectural register file, its status register and its top.
// Assumes a single processor clock and a synchronous, active-high reset.
package car_pkg;
  localparam int DATA_W_DEF = 32;
  localparam int ADDR_W_DEF = 32;
  localparam int NUM_GPR = 32;
  localparam int GPR_IDX_W = 5;
  localparam int SEL_W = 16;
  localparam int MAX_SPECIAL = 16;
  localparam int NUM_SPECIAL_DEF = 2;
  localparam logic [15:0] SEL_PC = 16'h0000;
  localparam logic [15:0] SEL_MSR = 16'h0001;
  localparam logic [4:0] ZERO_IDX = 5'h00;
  localparam logic [4:0] IRQ_RET_IDX = 5'h0e;
  localparam logic [4:0] USER_RET_IDX = 5'h0f;
  localparam logic [4:0] BRK_RET_IDX = 5'h10;
  localparam logic [4:0] EXC_RET_IDX = 5'h11;
  // Bit positions counted from the most significant bit, which is bit 0
  localparam int CC_POS_32 = 0;
  localparam int CC_POS_64 = 32;
  localparam int CARRY_POS_32 = 29;
  localparam int CARRY_POS_64 = 61;
  localparam logic [63:0] MSR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] VECTOR_BASE_DEF = 64'h0000_0000_0000_0000;

  // Converts a big-endian bit number into a vector index
  function automatic int car_msb_bit(input int width, input int pos);
    return width - 1 - pos;
  endfunction : car_msb_bit
endpackage : car_pkg

// file: rtl/car_rf_if.sv
// Port bundle between the register-file control and its storage array.
// Assumes both ends sit on the processor clock.
`timescale 1ns/1ps
interface car_rf_if #(
  parameter int W = car_pkg::DATA_W_DEF
);
  logic wen;
  logic [car_pkg::GPR_IDX_W-1:0] waddr;
  logic [W-1:0] wdata;
  logic [car_pkg::GPR_IDX_W-1:0] ra_addr;
  logic [car_pkg::GPR_IDX_W-1:0] rb_addr;
  logic [W-1:0] ra_data;
  logic [W-1:0] rb_data;
  modport mem (input wen, waddr, wdata, ra_addr, rb_addr, output ra_data, rb_data);
  modport core (output wen, waddr, wdata, ra_addr, rb_addr, input ra_data, rb_data);
endinterface : car_rf_if

// file: rtl/car_gpr_mem.sv
// Storage array of the general registers with two registered read ports.
// Assumes contents are set only by configuration load; no reset reaches it.
`timescale 1ns/1ps
module car_gpr_mem #(
  parameter int W = car_pkg::DATA_W_DEF
) (
  input wire logic core_clk,
  car_rf_if.mem rf
);
  import car_pkg::*;
  // Configuration load clears every entry; one writing process keeps a single driver
  logic [W-1:0] mem_q [NUM_GPR] = '{default: '0};
  logic [W-1:0] ra_ff;
  logic [W-1:0] rb_ff;

  // No reset input here, so external resets leave the contents alone
  always_ff @(posedge core_clk) begin
    if (rf.wen && rf.waddr != ZERO_IDX) begin
      mem_q[rf.waddr] <= rf.wdata;
    end
    ra_ff <= (rf.ra_addr == ZERO_IDX) ? '0 : mem_q[rf.ra_addr];
    rb_ff <= (rf.rb_addr == ZERO_IDX) ? '0 : mem_q[rf.rb_addr];
  end

  assign rf.ra_data = ra_ff;
  assign rf.rb_data = rb_ff;
endmodule : car_gpr_mem

// file: rtl/car_msr.sv
// Machine status register with separately held carry.
// Assumes move and bit-operation strobes are one-cycle pulses from the core.
`timescale 1ns/1ps
module car_msr #(
  parameter int W = car_pkg::DATA_W_DEF,
  parameter int CARRY_IDX = 2,
  parameter int CC_IDX = 31
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mts_en,
  input wire logic [W-1:0] mts_data,
  input wire logic bitop_set,
  input wire logic bitop_clr,
  input wire logic [W-1:0] bitop_mask,
  input wire logic alu_carry_we,
  input wire logic alu_carry,
  output logic carry_now,
  output logic [W-1:0] msr_read
);
  import car_pkg::*;
  logic [W-1:0] msr_ff;
  logic [W-1:0] nxt_msr;
  logic carry_ff;
  logic nxt_carry;
  logic bitop;
  logic bit_carry;
  logic [W-1:0] keep_mask;
  logic [W-1:0] bitop_val;

  assign bitop = bitop_set | bitop_clr;
  assign keep_mask = ~((W'(1) << CARRY_IDX) | (W'(1) << CC_IDX));
  assign bitop_val = bitop_set ? (msr_ff | bitop_mask) : (msr_ff & ~bitop_mask);
  assign bit_carry = bitop_mask[CARRY_IDX] ? bitop_set : carry_ff;
  // Bit operations move carry at once; a move waits for the edge
  assign carry_now = (bitop && !mts_en) ? bit_carry : carry_ff;
  // Written copy bit is masked out of storage
  assign nxt_msr = mts_en ? (mts_data & keep_mask) :
                   bitop ? (bitop_val & keep_mask) : msr_ff;
  assign nxt_carry = mts_en ? mts_data[CARRY_IDX] :
                     bitop ? bit_carry :
                     alu_carry_we ? alu_carry : carry_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      msr_ff <= MSR_RESET[W-1:0] & keep_mask;
      carry_ff <= MSR_RESET[CARRY_IDX];
    end else begin
      msr_ff <= nxt_msr;
      carry_ff <= nxt_carry;
    end
  end

  always_comb begin
    msr_read = msr_ff;
    msr_read[CARRY_IDX] = carry_now;
    msr_read[CC_IDX] = carry_now;
  end
endmodule : car_msr

// file: verif/car_arch_regs_tb.sv
// Self-checking bench for the architectural register file, its counter and status.
// Assumes the default 32-bit configuration on a 40 MHz processor clock.
`timescale 1ns/1ps
module car_arch_regs_tb;
  import car_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] rd_a_addr = '0, rd_b_addr = '0, wb_addr = '0;
  logic [31:0] rd_a_data, rd_b_data, program_counter, mfs_data, machine_status;
  logic [31:0] branch_target_save, wb_data = '0, ret_addr = '0, pc_next = '0;
  logic [31:0] mts_data = '0, bitop_mask = '0;
  logic wb_en = 1'b0, irq_take = 1'b0, brk_take = 1'b0, exc_take = 1'b0;
  logic exc_in_delay = 1'b0, pc_load = 1'b0, mfs_en = 1'b0, mts_en = 1'b0;
  logic status_bit_set = 1'b0, status_bit_clear = 1'b0, alu_carry_we = 1'b0;
  logic alu_carry = 1'b0, carry;
  logic [15:0] special_selector = '0;
  int n_mismatch = 0;
  int tests_run = 0;

  always #12.5 core_clk = ~core_clk;

  car_arch_regs car_arch_regs_i (.core_clk(core_clk), .rst(rst), .rd_a_addr(rd_a_addr),
    .rd_b_addr(rd_b_addr), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .wb_en(wb_en),
    .wb_addr(wb_addr), .wb_data(wb_data), .irq_take(irq_take), .brk_take(brk_take),
    .exc_take(exc_take), .exc_in_delay(exc_in_delay), .ret_addr(ret_addr),
    .pc_load(pc_load), .pc_next(pc_next), .program_counter(program_counter),
    .mfs_en(mfs_en), .mts_en(mts_en), .special_selector(special_selector),
    .mts_data(mts_data), .mfs_data(mfs_data), .status_bit_set(status_bit_set),
    .status_bit_clear(status_bit_clear), .bitop_mask(bitop_mask),
    .alu_carry_we(alu_carry_we), .alu_carry(alu_carry), .carry(carry),
    .machine_status(machine_status), .branch_target_save(branch_target_save));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc();
    @(negedge core_clk);
  endtask : cyc

  task automatic gpr_wr(input logic [4:0] a, input logic [31:0] d);
    wb_en = 1'b1;
    wb_addr = a;
    wb_data = d;
    cyc();
    wb_en = 1'b0;
    cyc();
  endtask : gpr_wr

  // Both read ports look at the same register
  task automatic gpr_chk(input logic [4:0] a, input logic [31:0] e);
    rd_a_addr = a;
    rd_b_addr = a;
    cyc();
    chk(rd_a_data, e);
    chk(rd_b_data, e);
  endtask : gpr_chk

  // Kind 0 interrupt, 1 break, 2 exception, 3 exception in a delay slot
  task automatic take(input int kind, input logic [31:0] a);
    ret_addr = a;
    irq_take = (kind == 0);
    brk_take = (kind == 1);
    exc_take = (kind >= 2);
    exc_in_delay = (kind == 3);
    cyc();
    {irq_take, brk_take, exc_take, exc_in_delay} = 4'h0;
  endtask : take

  task automatic mfs(input logic [15:0] sel);
    mfs_en = 1'b1;
    special_selector = sel;
    cyc();
    mfs_en = 1'b0;
  endtask : mfs

  // Status must keep the old value until the edge that takes the move
  task automatic move_to_special(input logic [15:0] sel, input logic [31:0] d, old_v, new_v);
    mts_en = 1'b1;
    special_selector = sel;
    mts_data = d;
    #1;
    chk(machine_status, old_v);
    cyc();
    mts_en = 1'b0;
    chk(machine_status, new_v);
    cyc();
  endtask : move_to_special

  task automatic bitop(input logic s, input logic [31:0] m, now_v, new_v);
    status_bit_set = s;
    status_bit_clear = !s;
    bitop_mask = m;
    #1;
    chk(machine_status, now_v);
    chk(carry, now_v[2]);
    cyc();
    status_bit_set = 1'b0;
    status_bit_clear = 1'b0;
    chk(machine_status, new_v);
    cyc();
  endtask : bitop

  task automatic t_gpr();
    gpr_chk(5'h03, 32'h0000_0000);
    gpr_wr(ZERO_IDX, 32'hffff_ffff);
    gpr_chk(ZERO_IDX, 32'h0000_0000);
    gpr_wr(5'h1f, 32'hdead_beef);
    gpr_wr(5'h01, 32'h8000_0001);
    gpr_chk(5'h1f, 32'hdead_beef);
    gpr_chk(5'h01, 32'h8000_0001);
  endtask : t_gpr

  task automatic t_events();
    take(0, 32'h0000_0100);
    gpr_chk(IRQ_RET_IDX, 32'h0000_0100);
    take(1, 32'h0000_0204);
    gpr_chk(BRK_RET_IDX, 32'h0000_0204);
    take(2, 32'h0000_1004);
    gpr_chk(EXC_RET_IDX, 32'h0000_1004);
    take(3, 32'h0000_3000);
    chk(branch_target_save, 32'h0000_3000);
    gpr_chk(EXC_RET_IDX, 32'h0000_1004);
    gpr_wr(USER_RET_IDX, 32'h0000_5550);
    gpr_chk(USER_RET_IDX, 32'h0000_5550);
  endtask : t_events

  task automatic t_pc();
    chk(program_counter, VECTOR_BASE_DEF[31:0]);
    pc_load = 1'b1;
    pc_next = 32'h0000_4a0c;
    cyc();
    pc_load = 1'b0;
    mfs(SEL_PC);
    chk(mfs_data, 32'h0000_4a0c);
    move_to_special(SEL_PC, 32'h0000_0bad, 32'h0, 32'h0);
    chk(program_counter, 32'h0000_4a0c);
    mfs(16'h0005);
    chk(mfs_data, 32'h0000_0000);
  endtask : t_pc

  task automatic t_msr();
    move_to_special(SEL_MSR, 32'h8000_0100, 32'h0, 32'h0000_0100);
    move_to_special(SEL_MSR, 32'h0000_0004, 32'h0000_0100, 32'h8000_0004);
    chk(carry, 1'b1);
    mfs(SEL_MSR);
    chk(mfs_data, 32'h8000_0004);
    bitop(1'b0, 32'h0000_0004, 32'h0, 32'h0);
    bitop(1'b1, 32'h0000_0204, 32'h8000_0004, 32'h8000_0204);
    bitop(1'b0, 32'h0000_0200, 32'h8000_0204, 32'h8000_0004);
    alu_carry_we = 1'b1;
    alu_carry = 1'b0;
    cyc();
    alu_carry_we = 1'b0;
    chk(machine_status, 32'h0000_0000);
  endtask : t_msr

  task automatic t_reset();
    gpr_wr(5'h07, 32'h1234_5678);
    move_to_special(SEL_MSR, 32'h0000_0004, 32'h0, 32'h8000_0004);
    rst = 1'b1;
    cyc();
    cyc();
    rst = 1'b0;
    chk(machine_status, 32'h0000_0000);
    chk(program_counter, VECTOR_BASE_DEF[31:0]);
    gpr_chk(5'h07, 32'h1234_5678);
    gpr_chk(5'h1f, 32'hdead_beef);
  endtask : t_reset

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (16) cyc();
    rst = 1'b0;
    cyc();
    t_gpr();
    t_events();
    t_pc();
    t_msr();
    t_reset();
    test_done();
  end
endmodule : car_arch_regs_tb
